// ### afc_top.sv
// Frame sequencer, reference chop control and result store of one converter.
// Assumes converter, remote modulators and CE RAM port share clk.
`timescale 1ns/1ns
`include "afc_params.svh"
module afc_top #(
   parameter int NRMT = 3,
   parameter int FIFO_DEPTH = 16,
   parameter int ACC_W = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] io_addr,
   input wire logic io_we,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   input wire logic slow_tick_clock,
   output logic conv_start,
   output logic [3:0] conv_input,
   output logic [1:0] decimator_length,
   input wire logic conv_valid,
   input wire logic [21:0] conv_data,
   output logic conv_ready,
   input wire logic [NRMT-1:0] rmt_bit,
   output logic [NRMT-1:0] remote_pair_enable,
   output logic preamp_gain8,
   output logic preamp_power,
   output logic pair0_differential_enable,
   output logic bias_rate_sel,
   input wire logic [7:0] accum_frames,
   output logic chop_polarity,
   output logic frame_sync,
   output logic ce_start,
   output logic ce_wr_valid,
   input wire logic ce_wr_ready,
   output logic [3:0] ce_wr_addr,
   output logic [31:0] ce_wr_data
);
   import afc_pkg::*;

   // **********************************
   // Register file
   // **********************************
   // Bytes 0x2100..0x2106 live in one small array, index = offset - base
   logic [7:0] mux_q [7];
   logic [7:0] fmt_q;
   logic [7:0] rate_q;
   logic [7:0] pre_q;
   logic [7:0] rmt_q;
   logic [7:0] rd_d;
   wire [15:0] mux_idx = io_addr - `AFC_OFS_SLOTS;
   wire hit_mux = (io_addr >= `AFC_OFS_SLOTS) && (io_addr <= `AFC_OFS_CHOP);
   wire hit_fmt = (io_addr == `AFC_OFS_FMT);
   wire hit_rate = (io_addr == `AFC_OFS_RATE);
   wire hit_pre = (io_addr == `AFC_OFS_PRE);
   wire hit_rmt = (io_addr == `AFC_OFS_RMT);

   // Write decode per mapped byte
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < 7; i++)
            mux_q[i] <= `AFC_REG_RST;
         fmt_q <= `AFC_REG_RST;
         rate_q <= `AFC_REG_RST;
         pre_q <= `AFC_REG_RST;
         rmt_q <= `AFC_REG_RST;
      end
      else if (io_we)
      begin
         if (hit_mux)
            mux_q[mux_idx[2:0]] <= io_wdata;
         if (hit_fmt)
            fmt_q <= io_wdata;
         if (hit_rate)
            rate_q <= io_wdata;
         if (hit_pre)
            pre_q <= io_wdata;
         if (hit_rmt)
            rmt_q <= io_wdata;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rd_d = 8'h00;
      if (hit_mux)
         rd_d = mux_q[mux_idx[2:0]];
      else if (hit_fmt)
         rd_d = fmt_q;
      else if (hit_rate)
         rd_d = rate_q;
      else if (hit_pre)
         rd_d = pre_q;
      else if (hit_rmt)
         rd_d = rmt_q;
   end

   // Read data is registered, one cycle behind the address
   always_ff @(posedge clk)
   begin
      if (!nrst)
         io_rdata <= 8'h00;
      else
         io_rdata <= rd_d;
   end

   // **********************************
   // Static analog controls
   // **********************************
   // Preamp gain and power both come from one shared bit, the differential bit is separate
   assign preamp_gain8 = pre_q[`AFC_PRE_BIT];
   assign preamp_power = pre_q[`AFC_PRE_BIT];
   assign pair0_differential_enable = fmt_q[`AFC_DIFF0_BIT];
   assign bias_rate_sel = rate_q[`AFC_RATE_BIT];
   assign decimator_length = fmt_q[`AFC_FIRLEN_LSB +: 2];
   assign remote_pair_enable = rmt_q[`AFC_RMT_LSB +: NRMT];

   // **********************************
   // Slow tick synchroniser
   // **********************************
   // Pin is asynchronous; stage one feeds only stage two
   logic tk1_q;
   logic tk2_q;
   logic tk3_q;
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         tk1_q <= 1'b0;
         tk2_q <= 1'b0;
         tk3_q <= 1'b0;
      end
      else
      begin
         tk1_q <= slow_tick_clock;
         tk2_q <= tk1_q;
         tk3_q <= tk2_q;
      end
   end
   wire tick_rise = tk2_q && !tk3_q;

   // **********************************
   // Frame sequencer
   // **********************************
   afc_state_t st_q;
   logic [3:0] slot_q;
   logic busy_q;
   logic [7:0] shd_q [6];
   afc_chop_t chop_mode_q;
   // Slot and chop settings seen by a running frame come from the shadow copy only
   wire [3:0] slots_raw = shd_q[0][`AFC_SLOTS_LSB +: 4];
   wire [3:0] nslots = (slots_raw > `AFC_MAX_SLOTS) ? `AFC_MAX_SLOTS : slots_raw;
   // Slot n sits in byte 0x2105 - n/2, even slots in the low nibble
   wire [2:0] sel_byte = 3'h5 - {1'b0, slot_q[2:1]} - {2'b00, slot_q[3]} * 3'h4;
   wire [7:0] sel_reg = shd_q[sel_byte];
   assign conv_input = slot_q[0] ? sel_reg[7:4] : sel_reg[3:0];
   wire slot_live = (st_q == AFC_ST_SLOT) && (slot_q < nslots);
   // A conversion starts only from the sequencer, once per slot
   assign conv_start = slot_live && !busy_q;
   wire fifo_in_ready;
   assign conv_ready = busy_q && fifo_in_ready;
   wire conv_take = conv_valid && conv_ready;
   wire last_slot = ({1'b0, slot_q} + 5'h01) >= {1'b0, nslots};
   wire enter_extra = (st_q == AFC_ST_WAIT) && tick_rise;
   wire leave_extra = (st_q == AFC_ST_EXTRA) && tick_rise;

   // State register; an empty frame goes straight to the tail wait
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         st_q <= AFC_ST_WAIT;
         slot_q <= 4'h0;
         busy_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            AFC_ST_SLOT:
            begin
               if (!slot_live)
                  st_q <= AFC_ST_WAIT;
               else if (conv_start)
                  busy_q <= 1'b1;
               else if (conv_take)
               begin
                  busy_q <= 1'b0;
                  slot_q <= slot_q + 4'h1;
                  if (last_slot)
                     st_q <= AFC_ST_WAIT;
               end
            end
            AFC_ST_WAIT:
               if (tick_rise)
                  st_q <= AFC_ST_EXTRA;
            AFC_ST_EXTRA:
               if (tick_rise)
               begin
                  st_q <= AFC_ST_SLOT;
                  slot_q <= 4'h0;
               end
            default:
               st_q <= AFC_ST_WAIT;
         endcase
      end
   end

   // Shadow copy taken as a frame begins, so a frame never mixes slot or chop settings
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < 6; i++)
            shd_q[i] <= `AFC_REG_RST;
         chop_mode_q <= AFC_CHOP_AUTO;
      end
      else if (leave_extra)
      begin
         for (int i = 0; i < 6; i++)
            shd_q[i] <= mux_q[i];
         chop_mode_q <= afc_chop_t'(mux_q[6][`AFC_CHOP_LSB +: 2]);
      end
   end

   // Frame sync high for the whole extra cycle; its rise starts the CE pass
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         frame_sync <= 1'b0;
         ce_start <= 1'b0;
      end
      else
      begin
         frame_sync <= (st_q == AFC_ST_EXTRA && !tick_rise) || enter_extra;
         ce_start <= enter_extra;
      end
   end

   // **********************************
   // Reference chop polarity
   // **********************************
   // Interval parity says whether this accumulation interval ends high or low
   logic [7:0] fcnt_q;
   logic par_q;
   logic chop_d;
   wire last_frame = ({1'b0, fcnt_q} + 9'h001) >= {1'b0, accum_frames};
   always_comb
   begin
      case (chop_mode_q)
         AFC_CHOP_LOW:
            chop_d = 1'b0;
         AFC_CHOP_HIGH:
            chop_d = 1'b1;
         AFC_CHOP_AUTO:
            chop_d = last_frame ? !par_q : !chop_polarity;
         AFC_CHOP_FRAME:
            chop_d = last_frame ? chop_polarity : !chop_polarity;
         default:
            chop_d = chop_polarity;
      endcase
   end

   // Polarity moves only at the start of the extra cycle
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         chop_polarity <= 1'b0;
         fcnt_q <= 8'h00;
         par_q <= 1'b0;
      end
      else if (enter_extra)
      begin
         chop_polarity <= chop_d;
         fcnt_q <= last_frame ? 8'h00 : fcnt_q + 8'h01;
         if (last_frame)
            par_q <= !par_q;
      end
   end

   // **********************************
   // Remote sensor decimators
   // **********************************
   // A first-order count of ones per frame; a limitation, not a full FIR
   logic [NRMT-1:0] pend_q;
   logic [ACC_W-1:0] hold_q [NRMT];
   logic [NRMT-1:0] pick;
   logic [1:0] pick_idx;
   wire rmt_push = (|pend_q) && !busy_q && fifo_in_ready;
   genvar g;
   generate
      for (g = 0; g < NRMT; g++)
      begin : g_rmt
         logic b1_q;
         logic b2_q;
         logic [ACC_W-1:0] acc_q;
         wire take = rmt_push && pick[g];
         // Stream sync, count, and hand-off at the frame end
         always_ff @(posedge clk)
         begin
            if (!nrst)
            begin
               b1_q <= 1'b0;
               b2_q <= 1'b0;
               acc_q <= '0;
               hold_q[g] <= '0;
               pend_q[g] <= 1'b0;
            end
            else
            begin
               b1_q <= rmt_bit[g];
               b2_q <= b1_q;
               if (enter_extra)
               begin
                  hold_q[g] <= acc_q;
                  acc_q <= '0;
               end
               else if (remote_pair_enable[g] && st_q != AFC_ST_EXTRA)
                  acc_q <= acc_q + ACC_W'(b2_q);
               // A new frame result wins over a clear in the same cycle
               if (enter_extra && remote_pair_enable[g])
                  pend_q[g] <= 1'b1;
               else if (take)
                  pend_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Lowest pending remote goes first
   always_comb
   begin
      pick = '0;
      pick_idx = 2'h0;
      for (int i = NRMT - 1; i >= 0; i--)
         if (pend_q[i])
         begin
            pick = '0;
            pick[i] = 1'b1;
            pick_idx = 2'(i);
         end
   end

   // **********************************
   // Result formatting and store FIFO
   // **********************************
   // Short results are sign-extended from bit 20 before the shift
   wire short_res = (decimator_length == `AFC_FIRLEN_SHORT);
   wire [21:0] res_ext = short_res ?
      {conv_data[`AFC_RES_SHORT-1], conv_data[`AFC_RES_SHORT-1:0]} : conv_data;
   wire [21:0] rmt_ext = 22'(hold_q[pick_idx]);
   wire [21:0] res_sel = conv_take ? res_ext : rmt_ext;
   wire [31:0] res_sh = {{(32 - `AFC_RES_LONG - `AFC_STORE_SHIFT){res_sel[21]}},
      res_sel, {`AFC_STORE_SHIFT{1'b0}}};
   // Local slot results own the port; remotes fill the gaps between them
   wire [3:0] res_addr = conv_take ? conv_input : `AFC_RMT_ADDR_BASE + {2'b00, pick_idx};
   afc_fifo_if #(.W(36)) rq();
   assign rq.in_valid = conv_take || rmt_push;
   assign rq.in_data = {res_addr, res_sh};
   assign fifo_in_ready = rq.in_ready;
   assign rq.out_ready = ce_wr_ready;
   assign ce_wr_valid = rq.out_valid;
   assign ce_wr_addr = rq.out_data[35:32];
   assign ce_wr_data = rq.out_data[31:0];

   // Back-pressure from the CE port reaches conv_ready through the FIFO
   afc_fifo #(.W(36), .DEPTH(FIFO_DEPTH), .AW($clog2(FIFO_DEPTH))) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .f(rq.fifo)
   );
endmodule

// ### afc_params.svh
// Constants of the frame, chop and converter control block.
// Assumes inclusion by bare name from the top module.
`ifndef AFC_PARAMS_SVH
`define AFC_PARAMS_SVH
// Register byte addresses
`define AFC_OFS_SLOTS 16'h2100
`define AFC_OFS_SEL_LAST 16'h2105
`define AFC_OFS_CHOP 16'h2106
`define AFC_OFS_FMT 16'h210c
`define AFC_OFS_RATE 16'h2200
`define AFC_OFS_PRE 16'h2704
`define AFC_OFS_RMT 16'h2709
// Field positions
`define AFC_SLOTS_LSB 4
`define AFC_CHOP_LSB 2
`define AFC_FIRLEN_LSB 1
`define AFC_DIFF0_BIT 4
`define AFC_RATE_BIT 5
`define AFC_PRE_BIT 5
`define AFC_RMT_LSB 3
// Reset value of every control byte
`define AFC_REG_RST 8'h00
// Counts and widths
`define AFC_MAX_SLOTS 4'hb
`define AFC_STORE_SHIFT 9
`define AFC_RES_SHORT 21
`define AFC_RES_LONG 22
`define AFC_FIRLEN_SHORT 2'h1
`define AFC_RMT_ADDR_BASE 4'hc
`endif

// ### afc_pkg.sv
// Types of the frame, chop and converter control block.
// Assumes the constants header sits in the same folder.
package afc_pkg;
   // Frame sequencer states
   typedef enum logic [1:0] {
      AFC_ST_SLOT = 2'b00,
      AFC_ST_WAIT = 2'b01,
      AFC_ST_EXTRA = 2'b10
   } afc_state_t;
   // Reference chop modes
   typedef enum logic [1:0] {
      AFC_CHOP_AUTO = 2'b00,
      AFC_CHOP_LOW = 2'b01,
      AFC_CHOP_HIGH = 2'b10,
      AFC_CHOP_FRAME = 2'b11
   } afc_chop_t;
endpackage

// ### afc_fifo_if.sv
// Valid/ready carrier between the control block and its result FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface afc_fifo_if #(parameter int W = 36);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ### afc_fifo.sv
// Result FIFO: DEPTH words in storage plus one registered output word.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ns
module afc_fifo #(
   parameter int W = 36,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic nrst,
   afc_fifo_if.fifo f
);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic ov_q;
   logic [W-1:0] od_q;
   wire push = f.in_valid && f.in_ready;
   wire load = (cnt_q != '0) && (!ov_q || f.out_ready);
   assign f.in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign f.out_valid = ov_q;
   assign f.out_data = od_q;
   // Storage array, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wp_q] <= f.in_data;
   end
   // Pointers, count and the output register
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         ov_q <= 1'b0;
         od_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (load)
         begin
            rp_q <= rp_q + 1'b1;
            od_q <= mem[rp_q];
            ov_q <= 1'b1;
         end
         else if (f.out_ready)
            ov_q <= 1'b0;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
      end
   end
endmodule

// ### afc_top_assertions.sv
// Concurrent checks on the top ports of afc_top.
// Assumes the bind below attaches it to every afc_top.
`timescale 1ns/1ns
module afc_top_assertions #(
   parameter int NRMT = 3
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] io_addr,
   input wire logic io_we,
   input wire logic [7:0] io_wdata,
   input wire logic conv_start,
   input wire logic [1:0] decimator_length,
   input wire logic [NRMT-1:0] remote_pair_enable,
   input wire logic preamp_gain8,
   input wire logic preamp_power,
   input wire logic pair0_differential_enable,
   input wire logic bias_rate_sel,
   input wire logic chop_polarity,
   input wire logic frame_sync,
   input wire logic ce_start,
   input wire logic ce_wr_valid,
   input wire logic ce_wr_ready,
   input wire logic [3:0] ce_wr_addr,
   input wire logic [31:0] ce_wr_data
);
   // ****
   // Checks
   // ****
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // One program pass start, then quiet
   sequence s_pass;
      ce_start ##1 !ce_start;
   endsequence
   // Write strobe to one control byte
   sequence s_wr(a);
      io_we && io_addr == a;
   endsequence
   a_gain_write: assert property (s_wr(16'h2704) |=> preamp_gain8 == $past(io_wdata[5]))
      else $error("gain select wrong");
   a_power_gain: assert property (preamp_power == preamp_gain8)
      else $error("preamp power differs from gain");
   a_fmt_write: assert property (s_wr(16'h210c) |=>
      pair0_differential_enable == $past(io_wdata[4]) && decimator_length == $past(io_wdata[2:1]))
      else $error("format byte not applied");
   a_bias_write: assert property (s_wr(16'h2200) |=> bias_rate_sel == $past(io_wdata[5]))
      else $error("bias select wrong");
   a_rmt_write: assert property (s_wr(16'h2709) |=> remote_pair_enable == $past(io_wdata[5:3]))
      else $error("remote enable wrong");
   a_sync_pass: assert property ($rose(frame_sync) |-> s_pass)
      else $error("no pass start at sync rise");
   a_pass_cause: assert property (ce_start |-> $rose(frame_sync))
      else $error("pass start without sync rise");
   a_chop_moment: assert property (!$rose(frame_sync) |-> $stable(chop_polarity))
      else $error("polarity moved outside extra cycle");
   a_no_conv_sync: assert property (frame_sync |-> !conv_start)
      else $error("conversion during extra cycle");
   a_conv_pulse: assert property (conv_start |=> !conv_start)
      else $error("start pulse too long");
   a_store_shift: assert property (ce_wr_valid |-> ce_wr_data[8:0] == 9'h000)
      else $error("stored word not shifted");
   a_wr_hold: assert property (ce_wr_valid && !ce_wr_ready |=>
      ce_wr_valid && $stable(ce_wr_addr) && $stable(ce_wr_data))
      else $error("write dropped or changed");
endmodule
bind afc_top afc_top_assertions #(.NRMT(NRMT)) u_afc_chk (.clk, .nrst, .io_addr, .io_we,
   .io_wdata, .conv_start, .decimator_length, .remote_pair_enable, .preamp_gain8, .preamp_power,
   .pair0_differential_enable, .bias_rate_sel, .chop_polarity, .frame_sync, .ce_start,
   .ce_wr_valid, .ce_wr_ready, .ce_wr_addr, .ce_wr_data);

// ### afc_ce_model.sv
// CE RAM write port and program sequencer model.
// Assumes the control block writes on the shared clock.
`timescale 1ns/1ns
module afc_ce_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [1:0] stall,
   input wire logic ce_wr_valid,
   output logic ce_wr_ready,
   input wire logic [3:0] ce_wr_addr,
   input wire logic [31:0] ce_wr_data,
   input wire logic ce_start
);
   logic [35:0] log_q [$];
   logic [1:0] ph = 2'h0;
   int passes = 0;
   // Ready moves at the falling edge; slow mode takes one word in four
   always @(negedge clk)
   begin
      ph = ph + 2'h1;
      ce_wr_ready = nrst && (stall == 2'h0 || (stall == 2'h1 && ph == 2'h0));
   end
   // Words kept in arrival order; each start pulse begins one pass
   always @(posedge clk)
   begin
      if (nrst && ce_wr_valid && ce_wr_ready)
         log_q.push_back({ce_wr_addr, ce_wr_data});
      if (nrst && ce_start)
         passes++;
   end
endmodule

// ### afc_top_tb.sv
// Self-checking bench of afc_top with converter and CE models.
// Assumes checker and CE model are compiled first.
`timescale 1ns/1ns
module afc_top_tb;
   typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] m; logic [8:0] st;} afc_row_t;
   logic clk, nrst, io_we, slow_tick_clock, conv_start, conv_valid, conv_ready, tick_on;
   logic preamp_gain8, preamp_power, pair0_differential_enable, bias_rate_sel;
   logic chop_polarity, frame_sync, ce_start, ce_wr_valid, ce_wr_ready;
   logic [15:0] io_addr;
   logic [7:0] io_wdata, io_rdata, accum_frames, rd_v;
   logic [3:0] conv_input, ce_wr_addr, ci;
   logic [1:0] decimator_length, stall;
   logic [21:0] conv_data, cval;
   logic [2:0] rmt_bit, remote_pair_enable;
   logic [31:0] ce_wr_data;
   logic [8:0] st_now;
   logic chop_s [$];
   logic [35:0] exp_q [$];
   int n_mismatch, n_checks, frames, nconv, last_nconv, sync_len, last_sync, k, j, c, nrm;
   logic [7:0] modes [4] = '{8'h04, 8'h08, 8'h0c, 8'h00};
   int chg_exp [4] = '{0, 0, 4, 6};
   // Expected state: remote[8:6], gain, power, differential, bias, length[1:0]
   afc_row_t rows [8] = '{'{16'h2704, 8'h20, 8'h20, 9'h030}, '{16'h2704, 8'h00, 8'h20, 9'h000},
      '{16'h210c, 8'h12, 8'h16, 9'h009}, '{16'h2704, 8'hff, 8'h20, 9'h039},
      '{16'h2200, 8'h20, 8'h20, 9'h03d}, '{16'h2709, 8'h28, 8'h38, 9'h17d},
      '{16'h2709, 8'h10, 8'h38, 9'h0bd}, '{16'h210c, 8'h04, 8'h16, 9'h0b6}};
   assign st_now = {remote_pair_enable, preamp_gain8, preamp_power, pair0_differential_enable,
      bias_rate_sel, decimator_length};
   afc_top u_afc_top (.clk, .nrst, .io_addr, .io_we, .io_wdata, .io_rdata, .slow_tick_clock,
      .conv_start, .conv_input, .decimator_length, .conv_valid, .conv_data, .conv_ready,
      .rmt_bit, .remote_pair_enable, .preamp_gain8, .preamp_power, .pair0_differential_enable,
      .bias_rate_sel, .accum_frames, .chop_polarity, .frame_sync, .ce_start, .ce_wr_valid,
      .ce_wr_ready, .ce_wr_addr, .ce_wr_data);
   afc_ce_model u_afc_ce_model (.clk, .nrst, .stall, .ce_wr_valid, .ce_wr_ready, .ce_wr_addr,
      .ce_wr_data, .ce_start);
   // ****
   // Clocks and models
   // ****
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Slow tick runs only when enabled, period of twenty clocks
   initial
   begin
      slow_tick_clock = 1'b0;
      forever #100 slow_tick_clock = tick_on ? ~slow_tick_clock : slow_tick_clock;
   end
   // Remote bit streams keep changing
   always @(negedge clk)
      rmt_bit <= rmt_bit + 3'h1;
   // Converter answers three cycles after a start and holds until taken
   initial
   begin
      conv_valid = 1'b0;
      conv_data = 22'h0;
      cval = 22'h2b3c4d;
      @(negedge clk);
      forever
      begin
         if (conv_start)
         begin
            ci = conv_input;
            repeat (3) @(negedge clk);
            conv_data = cval;
            conv_valid = 1'b1;
            for (j = 0; j < 2000 && !conv_ready; j++)
               @(negedge clk);
            if (j == 2000)
            begin
               n_mismatch++;
               test_done();
            end
            exp_q.push_back({ci, (decimator_length == 2'h1) ? {{11{cval[20]}}, cval[20:0]} << 9
               : {{10{cval[21]}}, cval} << 9});
            @(negedge clk);
            conv_valid = 1'b0;
            conv_data = ~cval;
            cval = cval + 22'h1a2b3b;
         end
         else
            @(negedge clk);
      end
   end
   // Frame monitor: conversions, sync length and polarity per frame
   always @(negedge clk)
   begin
      nconv += conv_start;
      if (frame_sync)
         sync_len++;
      else if (sync_len != 0)
      begin
         last_sync = sync_len;
         sync_len = 0;
      end
      if (ce_start)
      begin
         last_nconv = nconv;
         nconv = 0;
         chop_s.push_back(chop_polarity);
         frames++;
      end
   end
   // ****
   // Tasks
   // ****
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      io_we = 1'b1;
      @(negedge clk);
      io_we = 1'b0;
      io_wdata = ~d;
   endtask
   task automatic rd(input logic [15:0] a);
      io_addr = a;
      @(negedge clk);
      rd_v = io_rdata;
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_frames(input int n);
      int t;
      t = frames + n;
      for (k = 0; k < 1000 * n && frames < t; k++)
         @(negedge clk);
      if (frames < t)
      begin
         n_mismatch++;
         test_done();
      end
   endtask
   // ****
   // Main sequence
   // ****
   initial
   begin
      nrst = 1'b0;
      io_we = 1'b0;
      io_addr = 16'h0;
      io_wdata = 8'h0;
      accum_frames = 8'h03;
      stall = 2'h0;
      tick_on = 1'b0;
      rmt_bit = 3'h0;
      repeat (8) @(negedge clk);
      check({io_rdata, st_now, frame_sync, chop_polarity, ce_wr_valid, conv_start}, 36'h0);
      nrst = 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         check({rd_v & rows[i].m, st_now}, {rows[i].d & rows[i].m, rows[i].st});
      end
      wr(16'h2107, 8'hff);
      rd(16'h2107);
      check({rd_v, st_now}, {8'h00, rows[7].st});
      wr(16'h2709, 8'h08);
      wr(16'h210c, 8'h14);
      wr(16'h2100, 8'h30);
      wr(16'h2105, 8'h21);
      wr(16'h2104, 8'h07);
      tick_on = 1'b1;
      // Every chop mode, changes counted over six frame steps
      for (int i = 0; i < 4; i++)
      begin
         wr(16'h2106, modes[i]);
         wait_frames(9);
         c = 0;
         for (k = chop_s.size() - 6; k < chop_s.size(); k++)
            c += (chop_s[k] != chop_s[k - 1]);
         check(36'(c), 36'(chg_exp[i]));
         if (i < 2)
            check(36'(chop_s[$]), 36'(i));
      end
      check(36'(last_nconv), 36'd3);
      check(36'(last_sync >= 18 && last_sync <= 22), 36'd1);
      check(36'(u_afc_ce_model.passes), 36'(frames));
      // Short results, clamped slot count, then fill and drain
      wr(16'h210c, 8'h12);
      wr(16'h2100, 8'hf0);
      stall = 2'h1;
      wait_frames(3);
      check(36'(last_nconv), 36'd11);
      stall = 2'h2;
      repeat (400) @(negedge clk);
      check({conv_ready, ce_wr_valid}, 36'h1);
      stall = 2'h1;
      wait_frames(3);
      stall = 2'h0;
      wr(16'h2100, 8'h00);
      wait_frames(3);
      check(36'(last_nconv), 36'd0);
      tick_on = 1'b0;
      repeat (300) @(negedge clk);
      nrm = 0;
      for (int i = 0; i < u_afc_ce_model.log_q.size(); i++)
         if (u_afc_ce_model.log_q[i][35:32] >= 4'hc)
            nrm++;
         else
            check(u_afc_ce_model.log_q[i], exp_q.pop_front());
      check(36'(exp_q.size()), 36'd0);
      check(36'(nrm > 0), 36'd1);
      nrst = 1'b0;
      repeat (3) @(negedge clk);
      check({io_rdata, st_now, frame_sync, chop_polarity, ce_wr_valid, ce_start}, 36'h0);
      nrst = 1'b1;
      rd(16'h2100);
      check(36'(rd_v), 36'h0);
      test_done();
   end
endmodule
